// File: rtl/ptc_pkg.sv
// Shared constants and types of the pulse timing capture block.
// Assumes one 25 MHz sampling clock for all users of the package.
package ptc_pkg;

    localparam int PTC_NCH      = 20;
    localparam int PTC_CH_W     = 5;
    localparam int PTC_TS_W     = 31;
    localparam int PTC_WORD_W   = 32;
    localparam int PTC_PNUM_W   = 8;

    localparam int PTC_CLK_NS   = 40;
    localparam int PTC_CLK_HZ   = 25_000_000;
    // Timeout interval base of 0.1 ms, in ns
    localparam int PTC_TICK_NS  = 100_000;
    localparam int PTC_TICK_CYC = PTC_TICK_NS / PTC_CLK_NS;
    localparam int PTC_PRE_W    = 12;

    // Interval limits in 0.1 ms ticks: 0.1 ms and 10000 ms
    localparam int PTC_IVL_W    = 17;
    localparam logic [PTC_IVL_W-1:0] PTC_IVL_MIN = 17'h00001;
    localparam logic [PTC_IVL_W-1:0] PTC_IVL_MAX = 17'h186A0;

    // Timeout mode setting
    localparam logic [1:0] PTC_TM_OFF = 2'h0;
    localparam logic [1:0] PTC_TM_PRE = 2'h1;
    localparam logic [1:0] PTC_TM_DEP = 2'h2;

    // Timeout status codes
    localparam logic [1:0] PTC_TS_NONE   = 2'h0;
    localparam logic [1:0] PTC_TS_ACTIVE = 2'h1;
    localparam logic [1:0] PTC_TS_UNUSED = 2'h2;

    typedef enum logic [3:0] {
        PTC_P_NONE,
        PTC_P_HIGH,
        PTC_P_LOW,
        PTC_P_CYC_R,
        PTC_P_CYC_F,
        PTC_P_FRQ_R,
        PTC_P_FRQ_F,
        PTC_P_DTL_R,
        PTC_P_DTL_F,
        PTC_P_DTH_R,
        PTC_P_DTH_F,
        PTC_P_LVL_H,
        PTC_P_LVL_L,
        PTC_P_ANG_PW,
        PTC_P_ANG_VAL
    } ptc_proc_t;

    // Result is the ratio num/den; plain times carry den = 1
    typedef struct packed {
        logic [PTC_WORD_W-1:0] num;
        logic [PTC_WORD_W-1:0] den;
    } ptc_res_t;

    // Configuration of one measurement slot
    typedef struct packed {
        ptc_proc_t             proc;
        logic [PTC_CH_W-1:0]   ch_sel;
        logic [1:0]            tmode;
        ptc_res_t              dflt;
        logic [PTC_PNUM_W-1:0] pulse_num;
        logic                  meas_pol;
        logic                  val_pol;
    } ptc_cfg_t;

endpackage : ptc_pkg

// File: rtl/ptc_inp.sv
// Input synchronisers, edge detectors and free-running time stamp.
// Assumes channel pins are asynchronous to clk.
`timescale 1ns/1ps
module ptc_inp
    import ptc_pkg::*;
#(
    parameter int NCH = ptc_pkg::PTC_NCH
)
(
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic [NCH-1:0]               pins,
    output logic      [NCH-1:0]               lvl,
    output logic      [NCH-1:0]               rise,
    output logic      [NCH-1:0]               fall,
    output logic      [ptc_pkg::PTC_TS_W-1:0] ts
);
    typedef struct packed {
        logic [NCH-1:0]      s1;
        logic [NCH-1:0]      s2;
        logic [NCH-1:0]      lvl;
        logic [NCH-1:0]      rise;
        logic [NCH-1:0]      fall;
        logic [PTC_TS_W-1:0] ts;
    } ptc_inp_st_t;

    ptc_inp_st_t st_ff;
    ptc_inp_st_t nxt_st;

    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.s1   = pins;
        nxt_st.s2   = st_ff.s1;
        // Edges come from the second stage only
        nxt_st.lvl  = st_ff.s2;
        nxt_st.rise = st_ff.s2 & ~st_ff.lvl;
        nxt_st.fall = ~st_ff.s2 & st_ff.lvl;
        // Wraps silently; differences stay correct modulo 2^31
        nxt_st.ts   = st_ff.ts + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign lvl  = st_ff.lvl;
    assign rise = st_ff.rise;
    assign fall = st_ff.fall;
    assign ts   = st_ff.ts;

endmodule : ptc_inp

// File: rtl/ptc_meas.sv
// One measurement slot: asynchronous time procedures with timeout
// monitoring, and angle-window pulse-width measurement.
// Assumes window limit events are one-cycle pulses on clk.
`timescale 1ns/1ps

// How it works
// - Interval without any edge on the channel raises timeout; edges restart it.
// - Each channel has its own interval, clamped to 0.1 ms .. 10000 ms.
// - Two-bit timeout mode: 0 off, 1 predefined value, 2 input dependent.
// - Predefined mode outputs the default value when a timeout occurs.
// - Default value is used only in predefined mode.
// - Input-dependent result per procedure; refused for unsupporting procedures.
// - Channel select picks input 00 through 19.
// - No-measurement procedure evaluates nothing.
// - High, low, cycle, frequency, four duty variants and level procedures.
// - Angular pulses count only if both edges lie in one window.
// - Width of n-th valid pulse delivered at upper window limit.
// - At upper limit, fewer than n pulses gives default value if monitored.
// - Angular procedures refuse input-dependent mode.
// - Validated pulses must fully enclose an active validate pulse.
// - Measure and validate polarity set independently.
// - Validate channel is the other member of the even/odd pair.
// - n-th validated pulse width delivered at upper window limit.
// - Timeout checked at periodic intervals of the channel's own period.
// - Status 0 no timeout, 1 timeout, 2 monitoring disabled.
// - Timeout ends when latest edge word differs from word at timeout start.
// - Input-dependent values: zero, time since edge, frequency from time since edge, or duty 1.0/0.0.
module ptc_meas
#(
    parameter int NCH = ptc_pkg::PTC_NCH
)
(
    input  wire logic                                    clk,
    input  wire logic                                    rst_n,
    input  wire logic [NCH-1:0]                          pins,
    input  wire ptc_pkg::ptc_cfg_t                       cfg,
    input  wire logic [NCH-1:0][ptc_pkg::PTC_IVL_W-1:0]  ivl_per,
    input  wire logic                                    win_lower,
    input  wire logic                                    win_upper,
    output ptc_pkg::ptc_res_t                            res,
    output logic                                         res_vld,
    output logic      [1:0]                              timeout_status,
    output logic                                         cfg_err
);
    import ptc_pkg::*;

    if (NCH < 2 || NCH > 32 || (NCH % 2) != 0)
    begin : g_bad_nch
        $error("ptc_meas: NCH must be even and within 2..32");
    end

    typedef struct packed {
        logic [PTC_TS_W-1:0]   last_rise;
        logic [PTC_TS_W-1:0]   last_fall;
        logic [PTC_WORD_W-1:0] last_word;
        logic [PTC_WORD_W-1:0] tout_word;
        logic [PTC_PRE_W-1:0]  pre_cnt;
        logic [PTC_IVL_W-1:0]  ivl_cnt;
        logic                  tout;
        logic                  in_win;
        logic                  p_act;
        logic [PTC_TS_W-1:0]   p_start;
        logic                  v_act;
        logic                  v_done;
        logic [PTC_PNUM_W-1:0] cnt;
        logic                  cap_ok;
        logic [PTC_TS_W-1:0]   cap_w;
        ptc_res_t              res;
        logic                  res_vld;
        logic [1:0]            status;
        logic                  err;
    } ptc_st_t;

    localparam logic [PTC_PRE_W-1:0] PRE_LAST =
        PTC_PRE_W'(PTC_TICK_CYC - 1);
    localparam logic [PTC_WORD_W-1:0] CLK_HZ_W =
        PTC_WORD_W'(PTC_CLK_HZ);
    localparam logic [PTC_WORD_W-1:0] ONE_W = 32'h00000001;

    ptc_st_t st_ff;
    ptc_st_t nxt_st;

    logic [NCH-1:0]      lvl;
    logic [NCH-1:0]      rise;
    logic [NCH-1:0]      fall;
    logic [PTC_TS_W-1:0] ts;

    ptc_inp #(
        .NCH  (NCH)
    ) u_inp (
        .clk  (clk),
        .rst_n(rst_n),
        .pins (pins),
        .lvl  (lvl),
        .rise (rise),
        .fall (fall),
        .ts   (ts)
    );

    function automatic ptc_res_t mk(
        input logic [PTC_WORD_W-1:0] num,
        input logic [PTC_WORD_W-1:0] den
    );
        ptc_res_t r;
        r.num = num;
        r.den = den;
        return r;
    endfunction : mk

    function automatic logic [PTC_WORD_W-1:0] w(
        input logic [PTC_TS_W-1:0] t
    );
        return {1'b0, t};
    endfunction : w

    logic                  ch_ok;
    logic                  ang;
    logic                  asy;
    logic [1:0]            mode;
    logic                  m_lvl;
    logic                  m_rise;
    logic                  m_fall;
    logic                  v_rise;
    logic                  v_fall;
    logic [PTC_CH_W-1:0]   v_ch;
    logic                  m_open;
    logic                  m_close;
    logic                  v_open;
    logic                  v_close;
    logic [PTC_IVL_W-1:0]  per;
    logic [PTC_TS_W-1:0]   d_r;
    logic [PTC_TS_W-1:0]   d_f;
    logic [PTC_TS_W-1:0]   since;
    logic                  tick;
    logic                  ivl_end;
    logic                  edge_any;
    logic                  evt;
    ptc_res_t              evt_res;
    ptc_res_t              dep_res;

    always_comb
    begin
        ch_ok  = 32'(cfg.ch_sel) < NCH;
        ang    = cfg.proc == PTC_P_ANG_PW || cfg.proc == PTC_P_ANG_VAL;
        asy    = ch_ok && !ang && cfg.proc != PTC_P_NONE;
        // Refused settings fall back to no monitoring
        nxt_st = st_ff;
        nxt_st.err = !ch_ok || cfg.tmode == 2'h3
            || (ang && cfg.tmode == PTC_TM_DEP)
            || (ang && cfg.pulse_num == '0);
        mode   = nxt_st.err ? PTC_TM_OFF : cfg.tmode;
        v_ch   = {cfg.ch_sel[PTC_CH_W-1:1], ~cfg.ch_sel[0]};
        m_lvl  = 1'b0;
        m_rise = 1'b0;
        m_fall = 1'b0;
        v_rise = 1'b0;
        v_fall = 1'b0;
        per    = PTC_IVL_MIN;
        if (ch_ok)
        begin
            m_lvl  = lvl[cfg.ch_sel];
            m_rise = rise[cfg.ch_sel];
            m_fall = fall[cfg.ch_sel];
            v_rise = rise[v_ch];
            v_fall = fall[v_ch];
            per    = ivl_per[cfg.ch_sel];
        end
        if (per < PTC_IVL_MIN)
            per = PTC_IVL_MIN;
        if (per > PTC_IVL_MAX)
            per = PTC_IVL_MAX;
        // Polarity picks which edge opens a pulse
        m_open  = cfg.meas_pol ? m_rise : m_fall;
        m_close = cfg.meas_pol ? m_fall : m_rise;
        v_open  = cfg.val_pol ? v_rise : v_fall;
        v_close = cfg.val_pol ? v_fall : v_rise;
        d_r      = ts - st_ff.last_rise;
        d_f      = ts - st_ff.last_fall;
        since    = ts - st_ff.last_word[PTC_WORD_W-1:1];
        edge_any = asy && (m_rise || m_fall);
        tick     = st_ff.pre_cnt == PRE_LAST;
        ivl_end  = tick && (st_ff.ivl_cnt >= per - 1'b1);

        // Edge-driven results of the time procedures
        unique case (cfg.proc)
            PTC_P_LOW, PTC_P_CYC_R, PTC_P_FRQ_R, PTC_P_DTL_R, PTC_P_DTH_R:
                evt = m_rise;
            PTC_P_HIGH, PTC_P_CYC_F, PTC_P_FRQ_F, PTC_P_DTL_F, PTC_P_DTH_F:
                evt = m_fall;
            PTC_P_LVL_H, PTC_P_LVL_L:
                evt = m_rise || m_fall;
            default:
                evt = 1'b0;
        endcase
        evt = evt && asy;
        unique case (cfg.proc)
            PTC_P_HIGH, PTC_P_CYC_R: evt_res = mk(w(d_r), ONE_W);
            PTC_P_LOW, PTC_P_CYC_F: evt_res = mk(w(d_f), ONE_W);
            PTC_P_FRQ_R: evt_res = mk(CLK_HZ_W, w(d_r));
            PTC_P_FRQ_F: evt_res = mk(CLK_HZ_W, w(d_f));
            PTC_P_DTL_R: evt_res = mk(w(d_f), w(d_r));
            PTC_P_DTL_F: evt_res = mk(w(d_f - d_r), w(d_f));
            PTC_P_DTH_R: evt_res = mk(w(d_r - d_f), w(d_r));
            PTC_P_DTH_F: evt_res = mk(w(d_r), w(d_f));
            PTC_P_LVL_H: evt_res = mk({31'h0, m_rise}, ONE_W);
            PTC_P_LVL_L: evt_res = mk({31'h0, m_fall}, ONE_W);
            default: evt_res = mk('0, ONE_W);
        endcase

        // Values shown in input-dependent timeout
        unique case (cfg.proc)
            PTC_P_CYC_R, PTC_P_CYC_F:
                dep_res = mk(w(since), ONE_W);
            PTC_P_FRQ_R, PTC_P_FRQ_F:
                dep_res = mk(CLK_HZ_W, w(since));
            PTC_P_DTL_R, PTC_P_DTL_F:
                dep_res = mk({31'h0, !m_lvl}, ONE_W);
            PTC_P_DTH_R, PTC_P_DTH_F:
                dep_res = mk({31'h0, m_lvl}, ONE_W);
            default:
                dep_res = mk('0, ONE_W);
        endcase

        nxt_st.res_vld = 1'b0;

        // Periodic interval timer, restarted by every edge
        nxt_st.pre_cnt = tick ? '0 : st_ff.pre_cnt + 1'b1;
        if (tick)
            nxt_st.ivl_cnt = ivl_end ? '0 : st_ff.ivl_cnt + 1'b1;
        if (edge_any)
        begin
            nxt_st.pre_cnt   = '0;
            nxt_st.ivl_cnt   = '0;
            nxt_st.last_word = {ts, m_rise};
            if (st_ff.tout && {ts, m_rise} != st_ff.tout_word)
                nxt_st.tout = 1'b0;
        end
        if (m_rise)
            nxt_st.last_rise = ts;
        if (m_fall)
            nxt_st.last_fall = ts;
        if (evt && !nxt_st.tout)
        begin
            nxt_st.res     = evt_res;
            nxt_st.res_vld = 1'b1;
        end
        if (asy && ivl_end && !edge_any && mode != PTC_TM_OFF)
        begin
            if (!st_ff.tout)
            begin
                nxt_st.tout      = 1'b1;
                nxt_st.tout_word = st_ff.last_word;
            end
            // Dependent value refreshed each interval so the elapsed time grows
            nxt_st.res     = (mode == PTC_TM_PRE) ? cfg.dflt : dep_res;
            nxt_st.res_vld = mode != PTC_TM_PRE || !st_ff.tout;
        end

        // Angle-window pulse-width measurement
        if (ch_ok && ang && win_lower)
        begin
            nxt_st.in_win = 1'b1;
            nxt_st.cnt    = '0;
            nxt_st.cap_ok = 1'b0;
            nxt_st.p_act  = 1'b0;
            nxt_st.tout   = 1'b0;
        end
        else if (ch_ok && ang && st_ff.in_win)
        begin
            if (m_open)
            begin
                // Pulse only counts if opened inside the window
                nxt_st.p_act   = 1'b1;
                nxt_st.p_start = ts;
                nxt_st.v_act   = 1'b0;
                nxt_st.v_done  = 1'b0;
            end
            // Same-cycle edges do not count as enclosing
            if (st_ff.p_act && v_open)
                nxt_st.v_act = 1'b1;
            if (st_ff.p_act && st_ff.v_act && v_close)
                nxt_st.v_done = 1'b1;
            if (st_ff.p_act && m_close)
            begin
                nxt_st.p_act = 1'b0;
                if (cfg.proc == PTC_P_ANG_PW || st_ff.v_done)
                begin
                    nxt_st.cnt = st_ff.cnt + 1'b1;
                    if (st_ff.cnt + 1'b1 == cfg.pulse_num && !st_ff.cap_ok)
                    begin
                        nxt_st.cap_ok = 1'b1;
                        nxt_st.cap_w  = ts - st_ff.p_start;
                    end
                end
            end
        end
        if (ch_ok && ang && win_upper && st_ff.in_win && !win_lower)
        begin
            // Open pulse at the limit is dropped, not counted
            nxt_st.in_win = 1'b0;
            nxt_st.p_act  = 1'b0;
            if (st_ff.cap_ok)
            begin
                nxt_st.res     = mk(w(st_ff.cap_w), ONE_W);
                nxt_st.res_vld = 1'b1;
                nxt_st.tout    = 1'b0;
            end
            else if (mode == PTC_TM_PRE)
            begin
                nxt_st.res     = cfg.dflt;
                nxt_st.res_vld = 1'b1;
                nxt_st.tout    = 1'b1;
            end
        end
        if (!ang && !asy)
            nxt_st.in_win = 1'b0;
        if (mode == PTC_TM_OFF || cfg.proc == PTC_P_NONE)
            nxt_st.tout = 1'b0;

        if (mode == PTC_TM_OFF || cfg.proc == PTC_P_NONE)
            nxt_st.status = PTC_TS_UNUSED;
        else
            nxt_st.status = nxt_st.tout ? PTC_TS_ACTIVE : PTC_TS_NONE;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_ff        <= '0;
            st_ff.res    <= '{num: '0, den: ONE_W};
            st_ff.status <= PTC_TS_UNUSED;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign res            = st_ff.res;
    assign res_vld        = st_ff.res_vld;
    assign timeout_status = st_ff.status;
    assign cfg_err        = st_ff.err;

endmodule : ptc_meas

// File: testbench/ptc_meas_sva.sv
// Port checker for the measurement slot, bound into ptc_meas.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module ptc_meas_chk
#(
    parameter int NCH = ptc_pkg::PTC_NCH
)
(
    input wire logic                                   clk,
    input wire logic                                   rst_n,
    input wire logic [NCH-1:0]                         pins,
    input wire ptc_pkg::ptc_cfg_t                      cfg,
    input wire logic [NCH-1:0][ptc_pkg::PTC_IVL_W-1:0] ivl_per,
    input wire logic                                   win_lower,
    input wire logic                                   win_upper,
    input wire ptc_pkg::ptc_res_t                      res,
    input wire logic                                   res_vld,
    input wire logic [1:0]                             timeout_status,
    input wire logic                                   cfg_err
);
    import ptc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic ang;
    assign ang = (cfg.proc == PTC_P_ANG_PW) || (cfg.proc == PTC_P_ANG_VAL);

    property p_vld_pulse;
        res_vld |=> !res_vld;
    endproperty
    property p_off_status;
        (cfg.tmode == PTC_TM_OFF) [*2] |=> timeout_status == PTC_TS_UNUSED;
    endproperty
    // Five cycles let edges already in the pipeline drain first
    property p_none_quiet;
        (cfg.proc == PTC_P_NONE) [*5] |=> !res_vld && timeout_status == PTC_TS_UNUSED;
    endproperty
    property p_mode_err;
        (cfg.tmode == 2'h3) [*2] |=> cfg_err;
    endproperty
    property p_ang_err;
        (ang && cfg.tmode == PTC_TM_DEP) [*2] |=> cfg_err && timeout_status == PTC_TS_UNUSED;
    endproperty
    property p_ch_err;
        (cfg.ch_sel >= NCH) [*2] |=> cfg_err;
    endproperty
    property p_pre_dflt;
        $rose(timeout_status == PTC_TS_ACTIVE) && $past(cfg.tmode) == PTC_TM_PRE
            |-> ##[0:1] (res_vld && res == cfg.dflt);
    endproperty
    property p_dep_zero;
        res_vld && timeout_status == PTC_TS_ACTIVE && cfg.tmode == PTC_TM_DEP
            && cfg.proc inside {PTC_P_HIGH, PTC_P_LOW, PTC_P_LVL_H, PTC_P_LVL_L}
            |-> res.num == 32'h0;
    endproperty
    property p_ang_upper;
        res_vld && ang |-> $past(win_upper);
    endproperty
    property p_tout_mode;
        timeout_status == PTC_TS_ACTIVE |-> $past(cfg.tmode) != PTC_TM_OFF;
    endproperty

    a_vld_pulse: assert property (p_vld_pulse)
        else $error("strobe over one cycle");
    a_off_status: assert property (p_off_status)
        else $error("status not unused when off");
    a_none_quiet: assert property (p_none_quiet)
        else $error("activity with no procedure");
    a_mode_err: assert property (p_mode_err)
        else $error("reserved mode accepted");
    a_ang_err: assert property (p_ang_err)
        else $error("dependent mode on angular");
    a_ch_err: assert property (p_ch_err)
        else $error("channel out of range");
    a_pre_dflt: assert property (p_pre_dflt)
        else $error("no default at timeout");
    a_dep_zero: assert property (p_dep_zero)
        else $error("dependent value not zero");
    a_ang_upper: assert property (p_ang_upper)
        else $error("angular result off upper limit");
    a_tout_mode: assert property (p_tout_mode)
        else $error("timeout while off");

    c_ang_res: cover property (res_vld && ang);
    c_tout: cover property (timeout_status == PTC_TS_ACTIVE);
    c_err: cover property (cfg_err);
endmodule : ptc_meas_chk

bind ptc_meas ptc_meas_chk #(.NCH(NCH)) ptc_meas_chk_i
(
    .clk(clk), .rst_n(rst_n), .pins(pins), .cfg(cfg), .ivl_per(ivl_per),
    .win_lower(win_lower), .win_upper(win_upper), .res(res), .res_vld(res_vld),
    .timeout_status(timeout_status), .cfg_err(cfg_err)
);

// File: testbench/ptc_ang_ref.sv
// Angle reference and result consumer on the far side of the slot.
// Assumes requests from the bench arrive just after a clock edge.
`timescale 1ns/1ps
module ptc_ang_ref
#(
    parameter int LAT = 2
)
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              req_lower,
    input  wire logic              req_upper,
    input  wire ptc_pkg::ptc_res_t res,
    input  wire logic              res_vld,
    output logic                   win_lower,
    output logic                   win_upper,
    output ptc_pkg::ptc_res_t      last_res,
    output logic [15:0]            n_res
);
    import ptc_pkg::*;
    logic [LAT-1:0] lo_q;
    logic [LAT-1:0] up_q;
    // Latency above one stands for a slow angle clock
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            lo_q     <= '0;
            up_q     <= '0;
            last_res <= '0;
            n_res    <= 16'h0;
        end
        else
        begin
            lo_q <= {lo_q[LAT-2:0], req_lower};
            up_q <= {up_q[LAT-2:0], req_upper};
            if (res_vld)
            begin
                last_res <= res;
                n_res    <= n_res + 16'h1;
            end
        end
    end
    assign win_lower = lo_q[LAT-1];
    assign win_upper = up_q[LAT-1];
endmodule : ptc_ang_ref

// File: testbench/tb_top.sv
// Self-checking bench for the measurement slot.
// Assumes the angle reference model and checker compile beside it.
`timescale 1ns/1ps
module tb_top;
    import ptc_pkg::*;
    typedef struct packed { ptc_proc_t proc; ptc_res_t exp; } ptc_row_t;
    logic                                 clk;
    logic                                 rst_n;
    logic [PTC_NCH-1:0]                   pins;
    ptc_cfg_t                             cfg;
    logic [PTC_NCH-1:0][PTC_IVL_W-1:0]    ivl_per;
    logic                                 req_lower;
    logic                                 req_upper;
    logic                                 win_lower;
    logic                                 win_upper;
    ptc_res_t                             res;
    ptc_res_t                             last_res;
    logic                                 res_vld;
    logic [1:0]                           timeout_status;
    logic                                 cfg_err;
    logic [15:0]                          n_res;
    int                                   err_count;
    int                                   samples_checked;
    int                                   k;
    int                                   n0;
    // Wave: 6 cycles high, 10 low, period 16, ends on a rise
    ptc_row_t rows [12] = '{
        '{PTC_P_HIGH, '{32'h6, 32'h1}}, '{PTC_P_LOW, '{32'hA, 32'h1}},
        '{PTC_P_CYC_R, '{32'h10, 32'h1}}, '{PTC_P_CYC_F, '{32'h10, 32'h1}},
        '{PTC_P_FRQ_R, '{32'h017D7840, 32'h10}}, '{PTC_P_FRQ_F, '{32'h017D7840, 32'h10}},
        '{PTC_P_DTL_R, '{32'hA, 32'h10}}, '{PTC_P_DTL_F, '{32'hA, 32'h10}},
        '{PTC_P_DTH_R, '{32'h6, 32'h10}}, '{PTC_P_DTH_F, '{32'h6, 32'h10}},
        '{PTC_P_LVL_H, '{32'h1, 32'h1}}, '{PTC_P_LVL_L, '{32'h0, 32'h1}}};

    ptc_meas #(.NCH(PTC_NCH)) ptc_meas_i
    (
        .clk(clk), .rst_n(rst_n), .pins(pins), .cfg(cfg), .ivl_per(ivl_per),
        .win_lower(win_lower), .win_upper(win_upper), .res(res), .res_vld(res_vld),
        .timeout_status(timeout_status), .cfg_err(cfg_err)
    );
    ptc_ang_ref #(.LAT(2)) ptc_ang_ref_i
    (
        .clk(clk), .rst_n(rst_n), .req_lower(req_lower), .req_upper(req_upper),
        .res(res), .res_vld(res_vld), .win_lower(win_lower), .win_upper(win_upper),
        .last_res(last_res), .n_res(n_res)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic conclude();
        if (err_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task automatic chk_res(input ptc_res_t got, input ptc_res_t exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: result %h, expected %h", $time, got, exp);
        end
    endtask : chk_res
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: flag %h, expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic wait_st(input logic [1:0] st, output int n);
        n = 0;
        while (timeout_status !== st && n < 4000)
        begin
            tick(1);
            n++;
        end
        if (n == 4000)
        begin
            err_count++;
            $display("wrong value at %0t: status wait ran out", $time);
            conclude();
        end
    endtask : wait_st
    task automatic pulse(input int ch, input int h, input int l);
        pins[ch] = 1'b1;
        tick(h);
        pins[ch] = 1'b0;
        tick(l);
    endtask : pulse
    task automatic win(input logic up);
        req_lower = !up;
        req_upper = up;
        tick(1);
        req_lower = 1'b0;
        req_upper = 1'b0;
        tick(4);
    endtask : win

    initial
    begin
        err_count = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        pins = '0;
        req_lower = 1'b0;
        req_upper = 1'b0;
        foreach (ivl_per[c]) ivl_per[c] = 17'h00001;
        cfg = '{proc: PTC_P_NONE, ch_sel: 5'h03, tmode: PTC_TM_OFF, dflt: '{32'h7, 32'h1},
                pulse_num: 8'h01, meas_pol: 1'b1, val_pol: 1'b1};
        tick(20);
        rst_n = 1'b1;
        tick(10);
        for (int i = 0; i < 12; i++)
        begin
            cfg.proc = rows[i].proc;
            repeat (3) pulse(3, 6, 10);
            pins[3] = 1'b1;
            tick(6);
            chk_res(last_res, rows[i].exp);
            chk_val(32'(timeout_status), 32'(PTC_TS_UNUSED));
            pins[3] = 1'b0;
            tick(10);
        end
        cfg.proc = PTC_P_NONE;
        // Second reset in mid-run
        rst_n = 1'b0;
        tick(3);
        chk_res(res, '{32'h0, 32'h1});
        chk_val(32'(timeout_status), 32'(PTC_TS_UNUSED));
        rst_n = 1'b1;
        tick(3);
        n0 = int'(n_res);
        repeat (3) pulse(3, 6, 10);
        chk_val(32'(n_res), 32'(n0));
        cfg.tmode = PTC_TM_PRE;
        cfg.proc = PTC_P_CYC_R;
        repeat (2) pulse(3, 6, 10);
        wait_st(PTC_TS_ACTIVE, k);
        chk_val(32'(k >= PTC_TICK_CYC - 20 && k <= PTC_TICK_CYC), 32'h1);
        tick(1);
        chk_res(last_res, cfg.dflt);
        pulse(3, 6, 10);
        chk_val(32'(timeout_status), 32'(PTC_TS_NONE));
        cfg.tmode = PTC_TM_DEP;
        cfg.proc = PTC_P_HIGH;
        wait_st(PTC_TS_ACTIVE, k);
        tick(2);
        chk_val(last_res.num, 32'h0);
        pulse(3, 6, 10);
        cfg.tmode = PTC_TM_PRE;
        cfg.proc = PTC_P_ANG_PW;
        cfg.pulse_num = 8'h02;
        tick(8);
        // Pulse opened before the window must not count
        pins[3] = 1'b1;
        tick(4);
        win(1'b0);
        pins[3] = 1'b0;
        tick(4);
        pulse(3, 4, 4);
        pulse(3, 5, 4);
        pulse(3, 9, 4);
        win(1'b1);
        chk_res(last_res, '{32'h5, 32'h1});
        chk_val(32'(timeout_status), 32'(PTC_TS_NONE));
        win(1'b0);
        pulse(3, 5, 4);
        win(1'b1);
        chk_res(last_res, cfg.dflt);
        chk_val(32'(timeout_status), 32'(PTC_TS_ACTIVE));
        // Low-active validate on the pair partner, channel 3 idles high
        cfg.proc = PTC_P_ANG_VAL;
        cfg.ch_sel = 5'h02;
        cfg.pulse_num = 8'h01;
        cfg.val_pol = 1'b0;
        pins[3] = 1'b1;
        tick(4);
        win(1'b0);
        pulse(2, 8, 4);
        pins[2] = 1'b1;
        tick(3);
        pins[3] = 1'b0;
        tick(3);
        pins[3] = 1'b1;
        tick(6);
        pins[2] = 1'b0;
        tick(4);
        win(1'b1);
        chk_res(last_res, '{32'hC, 32'h1});
        for (int i = 0; i < 3; i++)
        begin
            cfg.ch_sel = (i == 0) ? 5'h14 : 5'h03;
            cfg.tmode = (i == 1) ? 2'h3 : PTC_TM_DEP;
            cfg.proc = (i == 2) ? PTC_P_ANG_PW : PTC_P_HIGH;
            tick(3);
            chk_val(32'(cfg_err), 32'h1);
            chk_val(32'(timeout_status), 32'(PTC_TS_UNUSED));
        end
        conclude();
    end
endmodule : tb_top
